// ===== logic/sie_defines.vh
// What this block does
// - Execute code suspends the CPU while 24 instruction bits shift in.
// - Execute the loaded instruction over the next four clocks.
// - Shift in the next 4-bit control code during the execute clocks.
// - First code after port entry is forced execute of a no-op.
// - After the forced code, 24 clocks load the first instruction.
// - Code 0000b shift-in and execute; 0001b shift-out; rest reserved.
// - Data launched on rising, captured on falling clock edge.
// - Programming clock is both shift clock and CPU clock.
`ifndef SIE_DEFINES_VH
`define SIE_DEFINES_VH
`define SIE_CODE_W 4
`define SIE_INSTR_W 24
`define SIE_INSTR_CNT 5'h18
`define SIE_EXEC_CNT 3'h4
`define SIE_FIRST_CNT 4'h9
`define SIE_CODE_EXEC 4'h0
`define SIE_CODE_REG_SHIFT_OUT_CODE 4'h1
`define SIE_NOP_INSTR 24'h000000
`define SIE_APB_CTRL 12'h000
`define SIE_APB_STAT 12'h004
`define SIE_APB_INSTR 12'h008
`define SIE_APB_COUNT 12'h00C
`endif

// ===== logic/sie_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; a level change is taken once stages two and
// three agree, which filters single-sample glitches on the pin.
module sie_sync (
   input wire pclk,
   input wire presetn,
   input wire din,
   output reg dout
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule // sie_sync

// ===== logic/sie_port.v
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sie_defines.vh"
module sie_port (
   input wire pclk,
   input wire presetn,
   input wire prog_serial_clock,
   input wire prog_serial_data,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg cpu_suspend,
   output reg cpu_exec_clk,
   output reg exec_valid,
   output reg [23:0] exec_instr,
   output reg reg_shift_out_code_req
);
   localparam ST_OFF = 3'h0;
   localparam ST_FIRST = 3'h1;
   localparam ST_CODE = 3'h2;
   localparam ST_SHIFT = 3'h3;
   localparam ST_EXEC = 3'h4;
   localparam ST_HOLD = 3'h5;

   wire sclk_s;
   wire sdat_s;
   reg sclk_d_r;
   reg [2:0] state_r;
   reg [4:0] cnt_r;
   reg [3:0] code_r;
   reg [23:0] sh_r;
   reg enable_r;
   reg reserved_seen_r;
   reg [15:0] exec_count_r;
   wire fall;
   wire rise;

   sie_sync u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .din(prog_serial_clock),
      .dout(sclk_s)
   );
   sie_sync u_dat (
      .pclk(pclk),
      .presetn(presetn),
      .din(prog_serial_data),
      .dout(sdat_s)
   );

   assign fall = sclk_d_r & ~sclk_s;
   assign rise = ~sclk_d_r & sclk_s;

   function [3:0] code_shift;
      input [3:0] cur;
      input bitin;
      begin
         code_shift = {bitin, cur[3:1]};
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d_r <= 1'b0;
         state_r <= ST_OFF;
         cnt_r <= 5'h00;
         code_r <= 4'h0;
         sh_r <= 24'h000000;
         cpu_suspend <= 1'b1;
         cpu_exec_clk <= 1'b0;
         exec_valid <= 1'b0;
         exec_instr <= 24'h000000;
         reg_shift_out_code_req <= 1'b0;
         reserved_seen_r <= 1'b0;
         exec_count_r <= 16'h0000;
      end else begin
         sclk_d_r <= sclk_s;
         exec_valid <= 1'b0;
         reg_shift_out_code_req <= 1'b0;
         cpu_exec_clk <= sclk_s;
         if (!enable_r) begin
            state_r <= ST_OFF;
            cpu_suspend <= 1'b1;
         end else begin
            case (state_r)
               ST_OFF: begin
                  state_r <= ST_FIRST;
                  cnt_r <= 5'h00;
               end
               ST_FIRST: begin
                  if (fall) begin
                     if (cnt_r == {1'b0, `SIE_FIRST_CNT} - 5'h01) begin
                        exec_valid <= 1'b1;
                        exec_instr <= `SIE_NOP_INSTR;
                        exec_count_r <= exec_count_r + 16'h0001;
                        state_r <= ST_SHIFT;
                        cnt_r <= 5'h00;
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_CODE: begin
                  if (fall) begin
                     code_r <= code_shift(code_r, sdat_s);
                     if (cnt_r == 5'h03) begin
                        cnt_r <= 5'h00;
                        if (code_shift(code_r, sdat_s) == `SIE_CODE_EXEC) begin
                           state_r <= ST_SHIFT;
                        end else if (code_shift(code_r, sdat_s) ==
                                     `SIE_CODE_REG_SHIFT_OUT_CODE) begin
                           reg_shift_out_code_req <= 1'b1;
                           state_r <= ST_HOLD;
                        end else begin
                           reserved_seen_r <= 1'b1;
                           state_r <= ST_HOLD;
                        end
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_SHIFT: begin
                  cpu_suspend <= 1'b1;
                  if (fall) begin
                     sh_r <= {sdat_s, sh_r[23:1]};
                     if (cnt_r == `SIE_INSTR_CNT - 5'h01) begin
                        cnt_r <= 5'h00;
                        code_r <= 4'h0;
                        state_r <= ST_EXEC;
                        exec_valid <= 1'b1;
                        exec_instr <= {sdat_s, sh_r[23:1]};
                        exec_count_r <= exec_count_r + 16'h0001;
                        cpu_suspend <= 1'b0;
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_EXEC: begin
                  // Execute while next code shifts in
                  cpu_suspend <= 1'b0;
                  if (fall) begin
                     code_r <= code_shift(code_r, sdat_s);
                     if (cnt_r == {2'b00, `SIE_EXEC_CNT} - 5'h01) begin
                        cnt_r <= 5'h00;
                        cpu_suspend <= 1'b1;
                        if (code_shift(code_r, sdat_s) == `SIE_CODE_EXEC) begin
                           state_r <= ST_SHIFT;
                        end else if (code_shift(code_r, sdat_s) ==
                                     `SIE_CODE_REG_SHIFT_OUT_CODE) begin
                           reg_shift_out_code_req <= 1'b1;
                           state_r <= ST_HOLD;
                        end else begin
                           reserved_seen_r <= 1'b1;
                           state_r <= ST_HOLD;
                        end
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_HOLD: begin
                  // Shift-out is outside this block; software resumes it
                  cpu_suspend <= 1'b1;
               end
               default: begin
                  state_r <= ST_OFF;
               end
            endcase
         end
      end
   end

   // APB slave, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_r <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `SIE_APB_CTRL: prdata <= {31'h00000000, enable_r};
               `SIE_APB_STAT: prdata <= {24'h000000, rise, sclk_s,
                  reserved_seen_r, cpu_suspend, 1'b0, state_r};
               `SIE_APB_INSTR: prdata <= {8'h00, exec_instr};
               `SIE_APB_COUNT: prdata <= {16'h0000, exec_count_r};
               default: pslverr <= 1'b1;
            endcase
            if (pwrite && paddr == `SIE_APB_CTRL) begin
               enable_r <= pwdata[0];
            end
         end
      end
   end
endmodule // sie_port

// ===== bench/sie_host_model.sv
`timescale 1ns/1ps
module sie_host_model (
   output logic prog_serial_clock,
   output logic prog_serial_data
);
   initial begin
      prog_serial_clock = 1'b0;
      prog_serial_data = 1'b1;
   end
   task automatic send(input logic [23:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         prog_serial_clock = 1'b1;
         prog_serial_data = v[i];
         #400;
         prog_serial_clock = 1'b0;
         #400;
      end
      // Released line must not look like a held bit
      prog_serial_data = ~prog_serial_data;
   endtask
endmodule // sie_host_model

// ===== bench/sie_port_properties.sv
`timescale 1ns/1ps
module sie_port_properties (
   input wire pclk,
   input wire presetn,
   input wire prog_serial_clock,
   input wire prog_serial_data,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire cpu_suspend,
   input wire cpu_exec_clk,
   input wire exec_valid,
   input wire [23:0] exec_instr,
   input wire reg_shift_out_code_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_apb_answer:
      assert property (psel && !penable |=> pready) else $error("no ready");
   chk_ready_access:
      assert property (pready |-> psel && penable) else $error("ready");
   chk_err_ready:
      assert property (pslverr |-> pready) else $error("lone error");
   chk_exec_pulse:
      assert property (exec_valid |=> !exec_valid) else $error("exec");
   chk_instr_hold:
      assert property ($changed(exec_instr) |-> exec_valid)
         else $error("instr moved");
   chk_code_pulse:
      assert property (reg_shift_out_code_req |=> !reg_shift_out_code_req) else $error("code");
   chk_clk_follow:
      assert property ($stable(prog_serial_clock) [*6] |->
         cpu_exec_clk == prog_serial_clock) else $error("exec clock");
   chk_fall_capture:
      assert property (exec_valid |-> !cpu_exec_clk) else $error("edge");
endmodule // sie_port_properties
bind sie_port sie_port_properties u_chk (.pclk(pclk), .presetn(presetn),
   .prog_serial_clock(prog_serial_clock), .prog_serial_data(prog_serial_data),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cpu_suspend(cpu_suspend), .cpu_exec_clk(cpu_exec_clk),
   .exec_valid(exec_valid), .exec_instr(exec_instr), .reg_shift_out_code_req(reg_shift_out_code_req));

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "sie_defines.vh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic cpu_suspend, cpu_exec_clk, exec_valid, reg_shift_out_code_req, sclk, sdat;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] exec_instr, last_instr;
   int errors, checks, n_exec, n_reg;
   sie_port DUT (.pclk(pclk), .presetn(presetn), .prog_serial_clock(sclk),
      .prog_serial_data(sdat), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_suspend(cpu_suspend),
      .cpu_exec_clk(cpu_exec_clk), .exec_valid(exec_valid),
      .exec_instr(exec_instr), .reg_shift_out_code_req(reg_shift_out_code_req));
   sie_host_model host (.prog_serial_clock(sclk), .prog_serial_data(sdat));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (exec_valid === 1'b1) begin
         last_instr <= exec_instr;
         n_exec <= n_exec + 1;
      end
      if (reg_shift_out_code_req === 1'b1) n_reg <= n_reg + 1;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task frame(input logic [23:0] v, input int n);
      @(posedge pclk);
      #37;
      host.send(v, n);
      repeat (8) @(posedge pclk);
   endtask
   task end_of_test;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #500000;
      errors++;
      end_of_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {errors, checks, n_exec, n_reg} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Link is ignored until enabled
      frame(24'h000000, 9);
      chk(n_exec, 0);
      apb(1'b1, 12'h000, 32'h00000001);
      apb(1'b0, 12'h000, 32'h00000000);
      chk(rd, 32'h00000001);
      apb(1'b0, 12'h010, 32'h00000000);
      chk(er, 1'b1);
      frame(24'h000000, 9);
      chk(n_exec, 1);
      chk(last_instr, `SIE_NOP_INSTR);
      // host sequencing, kept by the stimulus
      frame(24'h2407FA, 12);
      chk(cpu_suspend, 1'b1);
      frame(24'h000240, 12);
      chk(n_exec, 2);
      chk(last_instr, 24'h2407FA);
      chk(cpu_suspend, 1'b0);
      apb(1'b0, 12'h008, 32'h00000000);
      chk(rd[23:0], 24'h2407FA);
      frame(`SIE_CODE_EXEC, 4);
      frame(24'h883B0A, 24);
      chk(last_instr, 24'h883B0A);
      frame(`SIE_CODE_REG_SHIFT_OUT_CODE, 4);
      chk(n_reg, 1);
      apb(1'b0, 12'h00C, 32'h00000000);
      chk(rd, 32'h00000003);
      end_of_test;
   end
endmodule // tb_top
